// ==== design/jtap_pkg.sv ====
package jtap_pkg;

   // Instruction chain geometry and codes
   localparam int          IR_W        = 4;
   localparam logic [3:0]  INS_EXTEST  = 4'h0;
   localparam logic [3:0]  INS_INTEST  = 4'h1;
   localparam logic [3:0]  INS_SAMPLE  = 4'h2;
   localparam logic [3:0]  INS_IDCODE  = 4'he;
   localparam logic [3:0]  INS_BYPASS  = 4'hf;
   // Fixed pattern loaded into the instruction chain on capture, low bits 01
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;

   // Identification chain; value is arbitrary, bit 0 must stay set
   localparam int          IDC_W       = 32;
   localparam logic [31:0] IDCODE_VAL  = 32'h0a5a_5001;

   // Shared port pins and their reset function select
   localparam int          PIN_N       = 5;
   localparam logic [4:0]  ALT_FUNCTION_BIT_RESET = 5'h1f;

   // Default boundary chain length
   localparam int          BSR_W_DEF   = 8;

   // Bit positions inside the synchroniser bundle
   localparam int          SY_TCK      = 0;
   localparam int          SY_TMS      = 1;
   localparam int          SY_TDI      = 2;
   localparam int          SY_TRST_N   = 3;
   localparam int          SY_PINS     = 4;

   // Consecutive high mode-select samples that force the reset state
   localparam int          TMS_RESET_RUN = 5;

   // Sixteen controller states
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jtap_state_t;

   // Data chain chosen by the current instruction
   typedef enum logic [1:0] {
      CH_BYPASS, CH_IDCODE, CH_BSR, CH_HOLD
   } jtap_chain_t;

endpackage : jtap_pkg

// ==== design/jtap_sync.sv ====
module jtap_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   // Asynchronous levels in, resynchronised levels out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } jtap_sync_st_t;

   jtap_sync_st_t r;
   jtap_sync_st_t next_r;

   // First stage only feeds the second stage, to let metastability settle
   always_comb begin
      next_r      = r;
      next_r.meta = d_i;
      next_r.held = r.meta;
   end

   // Registered stages
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.held;

endmodule : jtap_sync

// ==== design/jtap_tap.sv ====
// Summary of operation
// (RL1) Controller state follows only test reset and mode-select samples at test clock rises.
// (RL2) Controller state decides when chains capture, shift and update.
// (RL3) Controller state picks instruction chain or data chain for each access.
// (RL4) Held instruction selects which data chain is captured, shifted or updated.
// (RL5) External and internal test act on held data, never capturing, shifting or updating; code still shifts serial data through the one-bit bypass cell.
// (RL6) Unimplemented instruction codes decode as bypass, keeping a serial path.
// (RL7) Active-low test reset resets controller and test circuitry, unrelated to test clock.
// (RL8) While test reset is low the controller sits in Test-Logic-Reset.
// (RL9) Entering Test-Logic-Reset by any route loads the identification instruction.
// (RL10) A static test clock leaves state and all chain contents unchanged.
// (RL11) Mode select sampled at each test clock rise chooses the next state.
// (RL12) Tester changes mode select on test clock falls.
// (RL13) Five consecutive high mode-select samples reach Test-Logic-Reset from anywhere.
// (RL14) Serial input sampled on rises goes into the chain that state and instruction choose.
// (RL15) Tester changes serial input on test clock falls.
// (RL16) Tester drives a roughly even free-running test clock, may stop it at either level.
// (RL17) Test logic advances only on test clock edges, independent of system timing; code detects those edges by sampling the test clock on mclk_i.
// (RL18) After device reset the shared pins select their test-port function.
// (RL19) Moving pins to general-purpose use needs the commit unlock first.
// (RL20) Instruction chain is four bits wide.
// (RL21) Serial output changes only on test clock falls.
// (RL22) Serial output is not driven unless shifting.
// (RL23) Device power-on reset also forces Test-Logic-Reset.
// (RL24) Full sixteen-state graph with standard capture, shift and update timing.
module jtap_tap #(
   parameter int BSR_W = jtap_pkg::BSR_W_DEF
) (
   // Clock and power-on reset
   input  wire logic                  mclk_i,
   input  wire logic                  sys_rst_i,
   // Test port pins
   input  wire logic                  tck_i,
   input  wire logic                  tms_i,
   input  wire logic                  tdi_i,
   input  wire logic                  trst_n_i,
   output logic                       tdo_o,
   output logic                       tdo_oe_n_o,
   // Boundary cells
   input  wire logic [BSR_W-1:0]      bsr_pins_i,
   output logic      [BSR_W-1:0]      bsr_drive_o,
   output logic                       bsr_extest_o,
   output logic                       bsr_intest_o,
   // Pin function select
   input  wire logic                  alt_function_bit_wr_i,
   input  wire logic [jtap_pkg::PIN_N-1:0] alt_function_bit_wdata_i,
   input  wire logic                  commit_unlock_i,
   output logic [jtap_pkg::PIN_N-1:0] pin_alt_function_select_o,
   // Status
   output jtap_pkg::jtap_state_t      tap_state_o
);

   localparam int SY_W = jtap_pkg::SY_PINS + BSR_W;

   typedef struct packed {
      jtap_pkg::jtap_state_t              state;
      logic [jtap_pkg::IR_W-1:0]          ir;
      logic [jtap_pkg::IR_W-1:0]          ir_sh;
      logic                               byp;
      logic [jtap_pkg::IDC_W-1:0]         idc_sh;
      logic [BSR_W-1:0]                   bsr_sh;
      logic [BSR_W-1:0]                   bsr_upd;
      logic                               tdo;
      logic                               tdo_oe_n;
      logic                               tck_prev;
      logic [jtap_pkg::PIN_N-1:0]         alt_function_bit;
   } jtap_st_t;

   localparam jtap_st_t RST_VAL = '{
      state:    jtap_pkg::ST_TLR,
      ir:       jtap_pkg::INS_IDCODE,
      ir_sh:    '0,
      byp:      1'b0,
      idc_sh:   '0,
      bsr_sh:   '0,
      bsr_upd:  '0,
      tdo:      1'b0,
      tdo_oe_n: 1'b1,
      tck_prev: 1'b0,
      alt_function_bit:    jtap_pkg::ALT_FUNCTION_BIT_RESET
   };

   jtap_st_t              r;
   jtap_st_t              next_r;
   logic [SY_W-1:0]       sy_q;
   logic                  tck_s;
   logic                  tms_s;
   logic                  tdi_s;
   logic                  trst_n_s;
   logic [BSR_W-1:0]      pins_s;
   logic                  tck_rise;
   logic                  tck_fall;
   jtap_pkg::jtap_chain_t chain;
   logic                  shifting;

   // All pins come from the tester's domain and are resynchronised first
   jtap_sync #(
      .W (SY_W)
   ) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({bsr_pins_i, trst_n_i, tdi_i, tms_i, tck_i}),
      .q_o       (sy_q)
   );

   assign tck_s    = sy_q[jtap_pkg::SY_TCK];
   assign tms_s    = sy_q[jtap_pkg::SY_TMS];
   assign tdi_s    = sy_q[jtap_pkg::SY_TDI];
   assign trst_n_s = sy_q[jtap_pkg::SY_TRST_N];
   assign pins_s   = sy_q[SY_W-1:jtap_pkg::SY_PINS];

   // Test clock edges; state and chains move only on one, except under test reset
   assign tck_rise = tck_s & ~r.tck_prev;  // [RL17]
   assign tck_fall = ~tck_s & r.tck_prev;  // [RL17]

   // Standard sixteen-state transition graph
   function automatic jtap_pkg::jtap_state_t tap_next(
      input jtap_pkg::jtap_state_t s,
      input logic                  m
   );
      jtap_pkg::jtap_state_t n;
      n = s;
      unique case (s)
         jtap_pkg::ST_TLR:    n = m ? jtap_pkg::ST_TLR    : jtap_pkg::ST_RTI;
         jtap_pkg::ST_RTI:    n = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_RTI;
         jtap_pkg::ST_SEL_DR: n = m ? jtap_pkg::ST_SEL_IR : jtap_pkg::ST_CAP_DR;
         jtap_pkg::ST_CAP_DR: n = m ? jtap_pkg::ST_EX1_DR : jtap_pkg::ST_SH_DR;
         jtap_pkg::ST_SH_DR:  n = m ? jtap_pkg::ST_EX1_DR : jtap_pkg::ST_SH_DR;
         jtap_pkg::ST_EX1_DR: n = m ? jtap_pkg::ST_UPD_DR : jtap_pkg::ST_PAU_DR;
         jtap_pkg::ST_PAU_DR: n = m ? jtap_pkg::ST_EX2_DR : jtap_pkg::ST_PAU_DR;
         jtap_pkg::ST_EX2_DR: n = m ? jtap_pkg::ST_UPD_DR : jtap_pkg::ST_SH_DR;
         jtap_pkg::ST_UPD_DR: n = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_RTI;
         jtap_pkg::ST_SEL_IR: n = m ? jtap_pkg::ST_TLR    : jtap_pkg::ST_CAP_IR;
         jtap_pkg::ST_CAP_IR: n = m ? jtap_pkg::ST_EX1_IR : jtap_pkg::ST_SH_IR;
         jtap_pkg::ST_SH_IR:  n = m ? jtap_pkg::ST_EX1_IR : jtap_pkg::ST_SH_IR;
         jtap_pkg::ST_EX1_IR: n = m ? jtap_pkg::ST_UPD_IR : jtap_pkg::ST_PAU_IR;
         jtap_pkg::ST_PAU_IR: n = m ? jtap_pkg::ST_EX2_IR : jtap_pkg::ST_PAU_IR;
         jtap_pkg::ST_EX2_IR: n = m ? jtap_pkg::ST_UPD_IR : jtap_pkg::ST_SH_IR;
         jtap_pkg::ST_UPD_IR: n = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_RTI;
      endcase
      return n;
   endfunction : tap_next

   // Instruction decode; any code not listed falls back to bypass
   always_comb begin
      unique case (r.ir)
         jtap_pkg::INS_IDCODE: chain = jtap_pkg::CH_IDCODE;  // [RL4]
         jtap_pkg::INS_SAMPLE: chain = jtap_pkg::CH_BSR;     // [RL4]
         jtap_pkg::INS_EXTEST: chain = jtap_pkg::CH_HOLD;    // [RL5]
         jtap_pkg::INS_INTEST: chain = jtap_pkg::CH_HOLD;    // [RL5]
         default:              chain = jtap_pkg::CH_BYPASS;  // [RL6]
      endcase
   end

   assign shifting = (r.state == jtap_pkg::ST_SH_DR) || (r.state == jtap_pkg::ST_SH_IR);

   // Next state of the whole controller
   always_comb begin
      next_r          = r;
      next_r.tck_prev = tck_s;

      // Rising edge: capture or shift in the state being left, then advance
      if (tck_rise) begin
         unique case (r.state)
            jtap_pkg::ST_CAP_IR: begin
               next_r.ir_sh = jtap_pkg::IR_CAPTURE;  // [RL2] [RL3]
            end
            jtap_pkg::ST_SH_IR: begin
               next_r.ir_sh = {tdi_s, r.ir_sh[jtap_pkg::IR_W-1:1]};  // [RL14] [RL20]
            end
            jtap_pkg::ST_CAP_DR: begin
               unique case (chain)
                  jtap_pkg::CH_IDCODE: next_r.idc_sh = jtap_pkg::IDCODE_VAL;  // [RL4]
                  jtap_pkg::CH_BSR:    next_r.bsr_sh = pins_s;                // [RL4]
                  jtap_pkg::CH_BYPASS: next_r.byp    = 1'b0;                  // [RL2]
                  jtap_pkg::CH_HOLD:   next_r.byp    = r.byp;                 // [RL5]
               endcase
            end
            jtap_pkg::ST_SH_DR: begin
               // Held-data instructions still pass serial data through one bit
               unique case (chain)
                  jtap_pkg::CH_IDCODE: begin
                     next_r.idc_sh = {tdi_s, r.idc_sh[jtap_pkg::IDC_W-1:1]};  // [RL14]
                  end
                  jtap_pkg::CH_BSR: begin
                     // Shift through the widened word so a one-cell chain still elaborates
                     next_r.bsr_sh = BSR_W'({tdi_s, r.bsr_sh} >> 1);  // [RL14]
                  end
                  jtap_pkg::CH_BYPASS: next_r.byp = tdi_s;  // [RL6]
                  jtap_pkg::CH_HOLD:   next_r.byp = tdi_s;  // [RL5]
               endcase
            end
            default: begin
            end
         endcase
         next_r.state = tap_next(r.state, tms_s);  // [RL1] [RL11] [RL13] [RL24]
      end

      // Falling edge: drive serial output and perform updates
      if (tck_fall) begin
         next_r.tdo_oe_n = ~shifting;  // [RL22]
         if (r.state == jtap_pkg::ST_SH_IR) begin
            next_r.tdo = r.ir_sh[0];  // [RL21]
         end else if (r.state == jtap_pkg::ST_SH_DR) begin
            unique case (chain)
               jtap_pkg::CH_IDCODE: next_r.tdo = r.idc_sh[0];  // [RL21]
               jtap_pkg::CH_BSR:    next_r.tdo = r.bsr_sh[0];  // [RL21]
               jtap_pkg::CH_BYPASS: next_r.tdo = r.byp;        // [RL21]
               jtap_pkg::CH_HOLD:   next_r.tdo = r.byp;        // [RL21]
            endcase
         end
         if (r.state == jtap_pkg::ST_UPD_IR) begin
            next_r.ir = r.ir_sh;  // [RL2] [RL3]
         end
         if (r.state == jtap_pkg::ST_UPD_DR && chain == jtap_pkg::CH_BSR) begin
            next_r.bsr_upd = r.bsr_sh;  // [RL2] [RL4]
         end
      end

      // Reset state always holds the identification instruction
      if (r.state == jtap_pkg::ST_TLR) begin
         next_r.ir       = jtap_pkg::INS_IDCODE;  // [RL9]
         next_r.tdo_oe_n = 1'b1;                  // [RL22]
      end

      // Test reset wins over any edge; it is a level, so no test clock is needed
      if (!trst_n_s) begin
         next_r.state    = jtap_pkg::ST_TLR;  // [RL7] [RL8]
         next_r.tdo_oe_n = 1'b1;              // [RL7]
      end

      // Pin function changes only commit while unlocked, guarding debugger access
      if (alt_function_bit_wr_i && commit_unlock_i) begin
         next_r.alt_function_bit = alt_function_bit_wdata_i;  // [RL19]
      end
   end

   // Power-on reset puts controller in reset state and pins on test function
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         r <= RST_VAL;  // [RL18] [RL23]
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from state
   assign tdo_o                     = r.tdo;
   assign tdo_oe_n_o                = r.tdo_oe_n;
   assign bsr_drive_o               = r.bsr_upd;
   assign bsr_extest_o              = (r.ir == jtap_pkg::INS_EXTEST);  // [RL5]
   assign bsr_intest_o              = (r.ir == jtap_pkg::INS_INTEST);  // [RL5]
   assign pin_alt_function_select_o = r.alt_function_bit;
   assign tap_state_o               = r.state;

   // Run of high mode-select samples, only for checking
   logic [2:0] ones_cnt;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ones_cnt <= '0;
      end else if (tck_rise) begin
         if (!tms_s) begin
            ones_cnt <= '0;
         end else if (ones_cnt != 3'(jtap_pkg::TMS_RESET_RUN)) begin
            ones_cnt <= ones_cnt + 3'h1;
         end
      end
   end

   a_trst_holds_reset: assert property (  // [RL8]
      @(posedge mclk_i) disable iff (sys_rst_i)
      !trst_n_s |=> (r.state == jtap_pkg::ST_TLR))
      else $error("Test reset did not hold reset state");

   a_reset_loads_idcode: assert property (  // [RL9]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (r.state == jtap_pkg::ST_TLR) |=> (r.ir == jtap_pkg::INS_IDCODE))
      else $error("Reset state did not load identification instruction");

   a_five_ones_reset: assert property (  // [RL13]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (ones_cnt == 3'(jtap_pkg::TMS_RESET_RUN)) |-> (r.state == jtap_pkg::ST_TLR))
      else $error("Five high mode samples did not reach reset state");

   a_static_clock_hold: assert property (  // [RL10]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (!tck_rise && !tck_fall && trst_n_s && r.state != jtap_pkg::ST_TLR)
      |=> ($stable(r.state) && $stable(r.ir) && $stable(r.bsr_sh) && $stable(r.idc_sh)))
      else $error("State changed without a test clock edge");

   a_idle_to_select: assert property (  // [RL11]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_rise && trst_n_s && tms_s && r.state == jtap_pkg::ST_RTI)
      |=> (r.state == jtap_pkg::ST_SEL_DR))
      else $error("Idle with mode high did not move to select");

   a_capture_ir_value: assert property (  // [RL2]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_rise && r.state == jtap_pkg::ST_CAP_IR)
      |=> (r.ir_sh == jtap_pkg::IR_CAPTURE))
      else $error("Instruction capture pattern missing");

   a_update_ir_load: assert property (  // [RL2] [RL3]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_fall && trst_n_s && r.state == jtap_pkg::ST_UPD_IR)
      |=> (r.ir == $past(r.ir_sh)))
      else $error("Instruction update did not load shifted value");

   a_hold_no_capture: assert property (  // [RL5]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (chain == jtap_pkg::CH_HOLD) |=> ($stable(r.bsr_sh) && $stable(r.bsr_upd)))
      else $error("Held-data instruction touched boundary chain");

   a_tdo_on_fall: assert property (  // [RL21]
      @(posedge mclk_i) disable iff (sys_rst_i)
      $changed(tdo_o) |-> $past(tck_fall))
      else $error("Serial output moved off a falling edge");

   a_tdo_idle_off: assert property (  // [RL22]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_fall && !shifting) |=> tdo_oe_n_o)
      else $error("Serial output driven outside shift");

   a_commit_gate: assert property (  // [RL19]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (alt_function_bit_wr_i && !commit_unlock_i) |=> $stable(pin_alt_function_select_o))
      else $error("Pin function changed while locked");

   a_tlr_oe_off: assert property (  // [RL22]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (r.state == jtap_pkg::ST_TLR) |=> tdo_oe_n_o)
      else $error("Serial output driven in reset state");

   a_bypass_capture: assert property (  // [RL6]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_rise && chain == jtap_pkg::CH_BYPASS && r.state == jtap_pkg::ST_CAP_DR)
      |=> !r.byp)
      else $error("Bypass bit did not capture zero");

   a_ir_shift_in: assert property (  // [RL14]
      @(posedge mclk_i) disable iff (sys_rst_i)
      (tck_rise && r.state == jtap_pkg::ST_SH_IR)
      |=> (r.ir_sh[jtap_pkg::IR_W-1] == $past(tdi_s)))
      else $error("Instruction chain missed the serial input bit");

endmodule : jtap_tap

// ==== testbench/jtap_tester.sv ====
// Behavioural test probe on the far side of the test port
module jtap_tester (
   // Test port drive
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   // Serial return from the device
   input  wire logic tdo_i,
   input  wire logic tdo_oe_n_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic tdo_line;

   // Released line reads high through its pull-up, never a stale bit
   assign tdo_line = tdo_oe_n_i ? 1'b1 : tdo_i;

   // Clock stands low between frames
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // One test clock period; levels move just after the fall
   task automatic step(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #62.5;
      q = tdo_line;
      tck_o = 1'b1;  // Even high and low halves
      #62.5;
      tck_o = 1'b0;
   endtask : step

   // Five high mode-select samples as a reset in place of the pin
   task automatic tlr_run();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
   endtask : tlr_run

   // Full scan from Run-Test/Idle back to Run-Test/Idle, LSB first
   task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (is_ir) begin
         step(1'b1, 1'b1, q);
      end
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : scan

endmodule : jtap_tester

// ==== testbench/test_jtap_tap.sv ====
// Self-checking bench for the test access port
module test_jtap_tap;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BW = 8;

   logic                  mclk_i;
   logic                  sys_rst_i;
   logic                  trst_n_i;
   logic                  alt_function_bit_wr_i;
   logic                  commit_unlock_i;
   logic                  tck;
   logic                  tms;
   logic                  tdi;
   logic                  tdo;
   logic                  tdo_oe_n;
   logic                  ext;
   logic                  intst;
   logic [BW-1:0]         pins;
   logic [BW-1:0]         drive;
   logic [4:0]            alt_function_bit_wdata;
   logic [4:0]            alt_function_bit_q;
   logic [31:0]           res;
   logic [31:0]           r;
   logic [31:0]           d;
   logic [31:0]           junk;
   logic                  q;
   jtap_pkg::jtap_state_t st;
   int                    num_errors;
   int                    tests_run;
   int unsigned           sd;
   string                 q_name[$];
   logic [31:0]           q_exp[$];
   event                  res_ev;

   // System clock, 5 ns period
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   jtap_tap #(.BSR_W(BW)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .bsr_pins_i(pins),
      .bsr_drive_o(drive), .bsr_extest_o(ext), .bsr_intest_o(intst),
      .alt_function_bit_wr_i(alt_function_bit_wr_i), .alt_function_bit_wdata_i(alt_function_bit_wdata),
      .commit_unlock_i(commit_unlock_i), .pin_alt_function_select_o(alt_function_bit_q),
      .tap_state_o(st)
   );

   jtap_tester u_tst (
      .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n)
   );

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Monitor takes the oldest note whenever a result is posted
   initial begin
      forever begin
         @(res_ev);
         chk(q_name.pop_front(), q_exp.pop_front(), res);
      end
   end

   // Note an expectation, then post the observed result
   task automatic look(input string nm, input logic [31:0] e, input logic [31:0] s);
      q_name.push_back(nm);
      q_exp.push_back(e);
      res = s;
      ->res_ev;
      #1;
   endtask : look

   task automatic do_scan(input logic ir, input int n, input logic [31:0] din,
                          input string nm, input logic [31:0] e);
      logic [31:0] o;
      u_tst.scan(ir, n, din, o);
      look(nm, e, o);
   endtask : do_scan

   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   // Hang guard, well past the expected run length
   initial begin
      #400000;
      num_errors++;
      print_verdict();
   end

   initial begin
      sys_rst_i = 1'b1;
      trst_n_i = 1'b1;
      alt_function_bit_wr_i = 1'b0;
      commit_unlock_i = 1'b0;
      alt_function_bit_wdata = '0;
      pins = '0;
      num_errors = 0;
      tests_run = 0;
      sd = $urandom(50466);
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i) sys_rst_i = 1'b0;
      repeat (10) @(negedge mclk_i);
      look("state", jtap_pkg::ST_TLR, st);
      look("alt_function_bit", 5'h1f, alt_function_bit_q);
      look("tdo_oe_n", 1, tdo_oe_n);
      u_tst.step(1'b0, 1'b1, q);
      repeat (8) @(negedge mclk_i);
      look("state", jtap_pkg::ST_RTI, st);
      // Test clock parked: nothing may move
      repeat (200) @(negedge mclk_i);
      look("state", jtap_pkg::ST_RTI, st);
      do_scan(1, 4, jtap_pkg::INS_IDCODE, "ir_cap", jtap_pkg::IR_CAPTURE);
      do_scan(0, 32, $urandom, "idcode", jtap_pkg::IDCODE_VAL);
      look("tdo_oe_n", 1, tdo_oe_n);
      // Unimplemented codes fall back to the one-bit path
      for (int k = 0; k < 4; k++) begin
         r = 32'h3 + $urandom_range(10);
         do_scan(1, 4, r, "ir_cap", jtap_pkg::IR_CAPTURE);
         d = $urandom;
         do_scan(0, BW, d, "bypass", {d[BW-2:0], 1'b0});
      end
      do_scan(1, 4, jtap_pkg::INS_SAMPLE, "ir_cap", jtap_pkg::IR_CAPTURE);
      r = $urandom;
      @(negedge mclk_i) pins = r[BW-1:0];
      repeat (8) @(negedge mclk_i);
      d = $urandom;
      do_scan(0, BW, d, "sample", {24'h0, pins});
      repeat (8) @(negedge mclk_i);
      look("drive", {24'h0, d[BW-1:0]}, drive);
      // External test works on held data only
      do_scan(1, 4, jtap_pkg::INS_EXTEST, "ir_cap", jtap_pkg::IR_CAPTURE);
      repeat (8) @(negedge mclk_i);
      look("extest", 1, ext);
      u_tst.scan(1'b0, BW, ~d, junk);
      look("hold_path", {25'h0, ~d[BW-2:0]}, {25'h0, junk[BW-1:1]});
      repeat (8) @(negedge mclk_i);
      look("drive_held", {24'h0, d[BW-1:0]}, drive);
      do_scan(1, 4, jtap_pkg::INS_INTEST, "ir_cap", jtap_pkg::IR_CAPTURE);
      repeat (8) @(negedge mclk_i);
      look("intest", 1, intst);
      look("drive_held", {24'h0, d[BW-1:0]}, drive);
      // Test reset pin with the clock parked
      @(negedge mclk_i) trst_n_i = 1'b0;
      repeat (8) @(negedge mclk_i);
      look("state", jtap_pkg::ST_TLR, st);
      look("intest", 0, intst);
      look("tdo_oe_n", 1, tdo_oe_n);
      @(negedge mclk_i) trst_n_i = 1'b1;
      repeat (8) @(negedge mclk_i);
      // Mode-select reset from the middle of a data shift
      u_tst.step(1'b0, 1'b1, q);
      do_scan(1, 4, jtap_pkg::INS_BYPASS, "ir_cap", jtap_pkg::IR_CAPTURE);
      u_tst.step(1'b1, 1'b1, q);
      u_tst.step(1'b0, 1'b1, q);
      u_tst.step(1'b0, 1'b1, q);
      repeat (8) @(negedge mclk_i);
      look("state", jtap_pkg::ST_SH_DR, st);
      look("tdo_oe_n", 0, tdo_oe_n);
      u_tst.tlr_run();
      repeat (8) @(negedge mclk_i);
      look("state", jtap_pkg::ST_TLR, st);
      u_tst.step(1'b0, 1'b1, q);
      do_scan(0, 32, $urandom, "idcode", jtap_pkg::IDCODE_VAL);
      // Pin function writes: locked then unlocked
      r = $urandom;
      r[4] = 1'b0;  // Locked write must differ from the reset value to be seen
      @(negedge mclk_i);
      alt_function_bit_wdata = r[4:0];
      alt_function_bit_wr_i = 1'b1;
      @(negedge mclk_i) alt_function_bit_wr_i = 1'b0;
      look("alt_function_bit_locked", 5'h1f, alt_function_bit_q);
      @(negedge mclk_i);
      alt_function_bit_wr_i = 1'b1;
      commit_unlock_i = 1'b1;
      @(negedge mclk_i);
      alt_function_bit_wr_i = 1'b0;
      commit_unlock_i = 1'b0;
      look("alt_function_bit_open", {27'h0, r[4:0]}, alt_function_bit_q);
      print_verdict();
   end

endmodule : test_jtap_tap
